//--- include/ddr4_lane_pkg.sv
// Package with register map, field positions and timing for the data lane block.
package ddr4_lane_pkg;
    // =====================================================
    // Register byte offsets
    localparam logic [7:0] MODE1_OFF = 8'h00;
    localparam logic [7:0] MODE4_OFF = 8'h04;
    localparam logic [7:0] MODE5_OFF = 8'h08;
    localparam logic [7:0] CTRL_OFF = 8'h0C;
    localparam logic [7:0] STAT_OFF = 8'h10;
    localparam logic [7:0] MASK_OFF = 8'h14;
    localparam logic [7:0] MEM_OFF  = 8'h20;
    // =====================================================
    // Field positions
    localparam int MR_W      = 16;
    localparam int TDQS_BIT  = 11;
    localparam int VREF_BIT  = 4;
    localparam int DM_BIT    = 10;
    localparam int WDBI_BIT  = 11;
    localparam int RDBI_BIT  = 12;
    localparam int PAR_LO    = 0;
    localparam int PAR_HI    = 2;
    localparam int RD_BIT    = 0;
    localparam int CRC_BIT   = 1;
    localparam int CT_BIT    = 2;
    localparam int VSEL_LO   = 4;
    localparam int BUSY_BIT  = 8;
    localparam int ALIN_BIT  = 9;
    localparam int ST_CRC    = 0;
    localparam int ST_PAR    = 1;
    localparam int ST_WR     = 2;
    localparam int ST_RD     = 3;
    localparam int ST_W      = 4;
    // =====================================================
    // Reset values
    localparam logic [MR_W-1:0] MR_RST   = 16'h0000;
    localparam logic [7:0]      CTRL_RST = 8'h00;
    localparam logic [ST_W-1:0] STAT_RST = 4'h0;
    // =====================================================
    // Timing
    localparam int CLK_NS     = 100;
    localparam int RD_HALF_NS = 400;
    localparam int PULSE_NS   = 1000;
    localparam int RECOV_NS   = 2000;
    localparam int RD_HALF    = (RD_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC  = PULSE_NS / CLK_NS;
    localparam int RECOV_CYC  = RECOV_NS / CLK_NS;
    localparam int BURST      = 8;
    typedef enum logic [1:0] {AL_IDLE, AL_CRC, AL_PAR} alert_t;
    typedef enum logic {RD_IDLE, RD_RUN} rd_t;
endpackage

//--- core/ddr4_data_lane.sv
// Data lane of a DDR4 device with APB mode registers, CRC, inversion and alert.
`timescale 1ns/10ps
// How it works
// - Write beats whose mask pin samples low are not stored.
// - Mask pin is sampled on both strobe edges along with each beat.
// - Mode register 5 bits A10 A11 A12 choose mask or inversion use.
// - On x8, mode register 1 bit A11 selects termination strobe instead of mask.
// - Inversion pin low inverts stored write data and driven read data.
// - With CRC enabled a CRC beat follows the last data beat.
// - Mode register 4 bit A4 lets lines 0 to 3 monitor the reference.
// - Data bus width is 4, 8 or 16 lines.
// - Read strobe is edge aligned with data, write strobe is sampled.
// - On x16 each byte has its own strobe pair, otherwise one pair.
// - Strobes are only valid as a complementary pair.
// - Write CRC error pulses alert low for a fixed interval.
// - Parity error holds alert low until recovery completes.
// - In connectivity test the alert pin becomes an input.
// - Parity is checked over command and address when enabled.
module ddr4_data_lane
    import ddr4_lane_pkg::*;
#(
    parameter int DQ_W  = 8,
    parameter int CMD_W = 22,
    parameter logic [15:0] POLY = 16'h1021
) (
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               rstn_i,
    // APB slave
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [7:0]         paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    // Data, strobe and shared mask or inversion pins
    input  wire logic [DQ_W-1:0]    dq_i,
    output logic      [DQ_W-1:0]    dq_o,
    output logic                    dq_oe_o,
    input  wire logic [DQ_W/16:0]   strobe_t_i,
    input  wire logic [DQ_W/16:0]   strobe_c_i,
    output logic      [DQ_W/16:0]   strobe_t_o,
    output logic      [DQ_W/16:0]   strobe_c_o,
    output logic                    strobe_oe_o,
    input  wire logic [DQ_W/16:0]   mask_invert_n_i,
    output logic      [DQ_W/16:0]   mask_invert_n_o,
    output logic                    mask_invert_n_oe_o,
    // Command parity inputs
    input  wire logic               ck_t_i,
    input  wire logic               cs_n_i,
    input  wire logic               parity_i,
    input  wire logic [CMD_W-1:0]   cmd_i,
    // Alert pin and misc outputs
    input  wire logic               alert_n_i,
    output logic                    alert_n_o,
    output logic                    alert_oe_o,
    output logic      [3:0]         vref_monitor_o,
    output logic                    irq_o
);
    localparam int LANES = (DQ_W == 16) ? 2 : 1;
    localparam int LW    = DQ_W / LANES;
    localparam int SW    = 3 * LANES + DQ_W + CMD_W + 4;
    localparam logic [3:0] LAST_D = 4'(BURST - 1);
    localparam logic [3:0] CRC_IX = 4'(BURST);

    // =====================================================
    // Input synchronisers
    logic [SW-1:0] raw, s1_q, s2_q, s3_q, stab_q, stab_d, chg;
    logic [LANES-1:0] n_st, n_sc, n_mi, e_st;
    logic [DQ_W-1:0]  n_dq;
    logic [CMD_W-1:0] n_cmd;
    logic n_al, n_ck, n_cs, n_par, e_ck;
    logic [SW-LANES-1:0] unused_chg;
    assign raw = {alert_n_i, ck_t_i, cs_n_i, parity_i, cmd_i, mask_invert_n_i, dq_i,
                  strobe_c_i, strobe_t_i};
    always_comb begin
        stab_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & stab_q);
        chg    = stab_d ^ stab_q;
    end
    assign {n_al, n_ck, n_cs, n_par, n_cmd, n_mi, n_dq, n_sc, n_st} = stab_d;
    assign {unused_chg, e_st} = chg;
    assign e_ck = chg[SW-2] & n_ck;
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            stab_q <= '0;
        end else begin
            s1_q   <= raw;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            stab_q <= stab_d;
        end
    end

    // =====================================================
    // Registers and mode decode
    logic [MR_W-1:0] mode1_q, mode1_d, mode4_q, mode4_d, mode5_q, mode5_d;
    logic [7:0]      ctrl_q, ctrl_d;
    logic [ST_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
    logic [31:0]     prdata_d;
    logic            pready_d, pslverr_d, wr, start, tdqs, dm_on, wdbi, rdbi, crc_en;
    logic [DQ_W-1:0] mem_q [BURST];
    logic [DQ_W-1:0] mem_d [BURST];
    rd_t             rd_q, rd_d;
    always_comb begin
        tdqs   = (DQ_W == 8) && mode1_q[TDQS_BIT];
        wdbi   = mode5_q[WDBI_BIT] && !tdqs;
        dm_on  = mode5_q[DM_BIT] && !wdbi && !tdqs;
        rdbi   = mode5_q[RDBI_BIT] && !tdqs;
        crc_en = ctrl_q[CRC_BIT];
    end
    assign wr = psel_i && penable_i && pwrite_i && pready_o;
    always_comb begin
        mode1_d   = mode1_q;
        mode4_d   = mode4_q;
        mode5_d   = mode5_q;
        ctrl_d    = ctrl_q;
        mask_d    = mask_q;
        stat_d    = stat_q;
        start     = 1'b0;
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b0;
        pready_d  = psel_i && !penable_i;
        if (wr) begin
            unique case (paddr_i)
                MODE1_OFF: mode1_d = pwdata_i[MR_W-1:0];
                MODE4_OFF: mode4_d = pwdata_i[MR_W-1:0];
                MODE5_OFF: mode5_d = pwdata_i[MR_W-1:0];
                CTRL_OFF: begin
                    ctrl_d = {pwdata_i[7:1], 1'b0};
                    start  = pwdata_i[RD_BIT] && (rd_q == RD_IDLE);
                end
                STAT_OFF: stat_d = stat_q & ~pwdata_i[ST_W-1:0];
                MASK_OFF: mask_d = pwdata_i[ST_W-1:0];
                default:  ;
            endcase
        end
        stat_d = stat_d | ev;
        if (psel_i && !penable_i) begin
            if (paddr_i == MODE1_OFF) begin
                prdata_d = {16'h0000, mode1_q};
            end else if (paddr_i == MODE4_OFF) begin
                prdata_d = {16'h0000, mode4_q};
            end else if (paddr_i == MODE5_OFF) begin
                prdata_d = {16'h0000, mode5_q};
            end else if (paddr_i == CTRL_OFF) begin
                prdata_d = {22'h00_0000, n_al, rd_q == RD_RUN, ctrl_q};
            end else if (paddr_i == STAT_OFF) begin
                prdata_d = {28'h000_0000, stat_q};
            end else if (paddr_i == MASK_OFF) begin
                prdata_d = {28'h000_0000, mask_q};
            end else if (paddr_i[7:5] == MEM_OFF[7:5] && paddr_i[1:0] == 2'b00) begin
                prdata_d = 32'(mem_q[paddr_i[4:2]]);
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            mode1_q   <= MR_RST;
            mode4_q   <= MR_RST;
            mode5_q   <= MR_RST;
            ctrl_q    <= CTRL_RST;
            stat_q    <= STAT_RST;
            mask_q    <= STAT_RST;
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            irq_o     <= 1'b0;
            vref_monitor_o <= 4'h0;
        end else begin
            mode1_q   <= mode1_d;
            mode4_q   <= mode4_d;
            mode5_q   <= mode5_d;
            ctrl_q    <= ctrl_d;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
            prdata_o  <= prdata_d;
            pready_o  <= pready_d;
            pslverr_o <= pslverr_d;
            irq_o     <= |(stat_q & mask_q);
            vref_monitor_o <= mode4_q[VREF_BIT] ? ctrl_q[VSEL_LO+:4] : 4'h0;
        end
    end

    // =====================================================
    // Write capture per byte lane
    function automatic logic [LW-1:0] crc_step(input logic [LW-1:0] c, input logic [LW-1:0] d);
        crc_step = {c[LW-2:0], 1'b0} ^ (c[LW-1] ? POLY[LW-1:0] : '0) ^ d;
    endfunction
    logic [3:0]      beat_q [LANES];
    logic [3:0]      beat_d [LANES];
    logic [DQ_W-1:0] wcrc_q, wcrc_d;
    logic            crc_err, wr_done, par_err, rd_done;
    always_comb begin
        logic [LW-1:0] ld;
        ld      = '0;
        mem_d   = mem_q;
        beat_d  = beat_q;
        wcrc_d  = wcrc_q;
        crc_err = 1'b0;
        wr_done = 1'b0;
        for (int l = 0; l < LANES; l++) begin
            ld = n_dq[l*LW+:LW];
            if (wdbi && !n_mi[l]) begin
                ld = ~ld;
            end
            // Any edge of a valid pair is a beat while no read burst runs.
            if (e_st[l] && (n_st[l] != n_sc[l]) && rd_q == RD_IDLE) begin
                if (beat_q[l] < CRC_IX) begin
                    if (!(dm_on && !n_mi[l])) begin
                        mem_d[beat_q[l][2:0]][l*LW+:LW] = ld;
                    end
                    wcrc_d[l*LW+:LW] = crc_step(wcrc_q[l*LW+:LW], n_dq[l*LW+:LW]);
                    beat_d[l] = beat_q[l] + 4'h1;
                    if (beat_q[l] == LAST_D && !crc_en) begin
                        beat_d[l] = 4'h0;
                        wcrc_d[l*LW+:LW] = '0;
                        wr_done = wr_done || (l == 0);
                    end
                end else begin
                    crc_err = crc_err || (n_dq[l*LW+:LW] != wcrc_q[l*LW+:LW]);
                    beat_d[l] = 4'h0;
                    wcrc_d[l*LW+:LW] = '0;
                    wr_done = wr_done || (l == 0);
                end
            end
        end
        par_err = e_ck && !n_cs && (|mode5_q[PAR_HI:PAR_LO]) && (^{n_cmd, n_par});
        ev = {rd_done, wr_done, par_err, crc_err};
    end
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            wcrc_q <= '0;
            for (int l = 0; l < LANES; l++) begin
                beat_q[l] <= 4'h0;
            end
            for (int i = 0; i < BURST; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wcrc_q <= wcrc_d;
            beat_q <= beat_d;
            mem_q  <= mem_d;
        end
    end

    // =====================================================
    // Read burst driver
    logic [3:0]      rbeat_q, rbeat_d, nb;
    logic [2:0]      rcnt_q, rcnt_d;
    logic [DQ_W-1:0] rcrc_q, rcrc_d, dq_d;
    logic [LANES-1:0] mi_d, stb_d;
    logic            oe_d, mioe_d, load;
    always_comb begin
        logic [LW-1:0] w;
        int zeros;
        w       = '0;
        zeros   = 0;
        rd_d    = rd_q;
        rbeat_d = rbeat_q;
        rcnt_d  = rcnt_q;
        rcrc_d  = rcrc_q;
        dq_d    = dq_o;
        mi_d    = mask_invert_n_o;
        stb_d   = strobe_t_o;
        oe_d    = dq_oe_o;
        mioe_d  = mask_invert_n_oe_o;
        load    = 1'b0;
        rd_done = 1'b0;
        nb      = rbeat_q;
        unique case (rd_q)
            RD_IDLE: if (start) begin
                rd_d   = RD_RUN;
                nb     = 4'h0;
                load   = 1'b1;
                rcrc_d = '0;
                stb_d  = '1;
                oe_d   = 1'b1;
                mioe_d = rdbi;
            end
            RD_RUN: if (rcnt_q != 3'h0) begin
                rcnt_d = rcnt_q - 3'h1;
            end else if (rbeat_q == (crc_en ? CRC_IX : LAST_D)) begin
                rd_d    = RD_IDLE;
                oe_d    = 1'b0;
                mioe_d  = 1'b0;
                stb_d   = '0;
                rd_done = 1'b1;
            end else begin
                nb    = rbeat_q + 4'h1;
                load  = 1'b1;
                stb_d = ~strobe_t_o;
            end
        endcase
        if (load) begin
            rbeat_d = nb;
            rcnt_d  = 3'(RD_HALF - 1);
            for (int l = 0; l < LANES; l++) begin
                if (nb < CRC_IX) begin
                    w = mem_q[nb[2:0]][l*LW+:LW];
                    zeros = 0;
                    for (int b = 0; b < LW; b++) begin
                        zeros = zeros + (w[b] ? 0 : 1);
                    end
                    mi_d[l] = !(rdbi && zeros > LW / 2);
                    dq_d[l*LW+:LW] = mi_d[l] ? w : ~w;
                    rcrc_d[l*LW+:LW] = crc_step(rcrc_d[l*LW+:LW], dq_d[l*LW+:LW]);
                end else begin
                    mi_d[l] = 1'b1;
                    dq_d[l*LW+:LW] = rcrc_q[l*LW+:LW];
                end
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            rd_q       <= RD_IDLE;
            rbeat_q    <= 4'h0;
            rcnt_q     <= 3'h0;
            rcrc_q     <= '0;
            dq_o       <= '0;
            dq_oe_o    <= 1'b0;
            strobe_t_o <= '0;
            strobe_c_o <= '1;
            strobe_oe_o <= 1'b0;
            mask_invert_n_o    <= '1;
            mask_invert_n_oe_o <= 1'b0;
        end else begin
            rd_q       <= rd_d;
            rbeat_q    <= rbeat_d;
            rcnt_q     <= rcnt_d;
            rcrc_q     <= rcrc_d;
            dq_o       <= dq_d;
            dq_oe_o    <= oe_d;
            strobe_t_o <= stb_d;
            strobe_c_o <= ~stb_d;
            strobe_oe_o <= oe_d;
            mask_invert_n_o    <= mi_d;
            mask_invert_n_oe_o <= mioe_d;
        end
    end

    // =====================================================
    // Alert sequencer
    alert_t    al_q, al_d;
    logic [7:0] acnt_q, acnt_d;
    always_comb begin
        al_d   = al_q;
        acnt_d = (acnt_q != 8'h00) ? acnt_q - 8'h01 : 8'h00;
        if (par_err) begin
            al_d   = AL_PAR;
            acnt_d = 8'(RECOV_CYC - 1);
        end else if (crc_err && al_q == AL_IDLE) begin
            al_d   = AL_CRC;
            acnt_d = 8'(PULSE_CYC - 1);
        end else if (al_q != AL_IDLE && acnt_q == 8'h00) begin
            al_d   = AL_IDLE;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            al_q       <= AL_IDLE;
            acnt_q     <= 8'h00;
            alert_n_o  <= 1'b1;
            alert_oe_o <= 1'b1;
        end else begin
            al_q       <= al_d;
            acnt_q     <= acnt_d;
            alert_n_o  <= (al_d == AL_IDLE);
            alert_oe_o <= !ctrl_q[CT_BIT];
        end
    end

    // =====================================================
    // Checks
    logic [2:0]    w_idx;
    logic [LW-1:0] ld0;
    logic          wr_ev0;
    assign w_idx  = beat_q[0][2:0];
    assign ld0    = n_dq[LW-1:0];
    assign wr_ev0 = e_st[0] && (n_st[0] != n_sc[0]) && rd_q == RD_IDLE && beat_q[0] < CRC_IX;
    mask_hold_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (wr_ev0 && dm_on && !n_mi[0]) |=> mem_q[$past(w_idx)][LW-1:0] ==
        $past(mem_q[w_idx][LW-1:0])) else $error("masked beat was stored");
    dbi_store_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (wr_ev0 && wdbi && !n_mi[0]) |=> mem_q[$past(w_idx)][LW-1:0] == ~$past(ld0))
        else $error("inverted beat stored wrong");
    crc_pulse_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (crc_err && !par_err && al_q == AL_IDLE) |=> !alert_n_o ##9 !alert_n_o ##1 alert_n_o)
        else $error("crc alert pulse wrong");
    par_hold_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        par_err |=> (!alert_n_o) [*8]) else $error("parity alert released early");
    alert_in_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ctrl_q[CT_BIT] |=> !alert_oe_o) else $error("alert driven in test mode");
    vref_off_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !mode4_q[VREF_BIT] |=> vref_monitor_o == 4'h0) else $error("vref monitor leaked");
    strobe_pair_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        strobe_oe_o |-> strobe_t_o == ~strobe_c_o) else $error("strobe not differential");
    edge_align_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (dq_oe_o && $past(dq_oe_o) && $changed(dq_o)) |-> $changed(strobe_t_o))
        else $error("read data not edge aligned");
    wr_done_c: cover property (@(posedge clock_i) disable iff (!rstn_i) wr_done);
    crc_err_c: cover property (@(posedge clock_i) disable iff (!rstn_i) crc_err);
    rd_done_c: cover property (@(posedge clock_i) disable iff (!rstn_i) rd_done);
endmodule

//--- bench/ddr4_ctrl_model.sv
// Host controller model that drives write bursts onto the data lane pins.
`timescale 1ns/10ps
module ddr4_ctrl_model
    import ddr4_lane_pkg::*;
#(
    parameter logic [15:0] POLY = 16'h1021
) (
    // Clock
    input  wire logic       clock_i,
    // Pins toward the device
    output logic      [7:0] dq_o,
    output logic            strobe_t_o,
    output logic            strobe_c_o,
    output logic            mask_n_o
);
    // ==========================================
    // Beats
    // The strobe pair stands still between frames.
    initial begin
        dq_o       = 8'h00;
        strobe_t_o = 1'b0;
        strobe_c_o = 1'b1;
        mask_n_o   = 1'b1;
    end
    // Data and mask change midway between strobe edges.
    task automatic send(input logic [7:0] data, input logic mask_n);
        dq_o       <= data;
        mask_n_o   <= mask_n;
        repeat (2) @(posedge clock_i);
        strobe_t_o <= ~strobe_t_o;
        strobe_c_o <= strobe_t_o;
        repeat (2) @(posedge clock_i);
    endtask
    task automatic frame(input logic [7:0] base, input logic [7:0] mask_n,
                         input logic with_crc, input logic bad);
        logic [7:0] crc;
        logic [7:0] data;
        crc = 8'h00;
        for (int k = 0; k < BURST; k++) begin
            data = base + 8'(k);
            send(data, mask_n[k]);
            crc = {crc[6:0], 1'b0} ^ (crc[7] ? POLY[7:0] : 8'h00) ^ data;
        end
        if (with_crc) begin
            send(crc ^ {7'h00, bad}, 1'b1);
        end
        dq_o     <= ~dq_o;
        mask_n_o <= 1'b1;
    endtask
endmodule

//--- bench/ddr4_data_lane_tb_top.sv
// Bench for the data lane: registers, write and read bursts, alert and test pins.
`timescale 1ns/10ps
module ddr4_data_lane_tb_top import ddr4_lane_pkg::*;;
    logic        clock_i   = 1'b0;
    logic        rstn_i    = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0000_0000;
    logic        ck_t_i    = 1'b0;
    logic        cs_n_i    = 1'b1;
    logic        parity_i  = 1'b0;
    logic [21:0] cmd_i     = 22'h00_0000;
    logic        alert_drv = 1'b1;
    logic [31:0] prdata_o, rd;
    logic [7:0]  dq_o, m_dq;
    logic [3:0]  vref_monitor_o;
    logic        pready_o, pslverr_o, dq_oe_o, strobe_t_o, strobe_c_o, strobe_oe_o, slv;
    logic        mask_invert_n_o, mask_invert_n_oe_o, alert_n_o, alert_oe_o, irq_o;
    logic        m_st, m_sc, m_mask;
    int          num_errors = 0;
    int          samples_checked = 0;
    wire logic [7:0] dq_i = dq_oe_o ? dq_o : m_dq;
    wire logic   st_i = strobe_oe_o ? strobe_t_o : m_st;
    wire logic   sc_i = strobe_oe_o ? strobe_c_o : m_sc;
    wire logic   mk_i = mask_invert_n_oe_o ? mask_invert_n_o : m_mask;
    wire logic   al_i = alert_oe_o ? alert_n_o : alert_drv;
    always #50 clock_i = ~clock_i;
    ddr4_data_lane #(.DQ_W(8)) ddr4_data_lane_inst (
        .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe_o(dq_oe_o), .strobe_t_i(st_i), .strobe_c_i(sc_i), .strobe_t_o(strobe_t_o),
        .strobe_c_o(strobe_c_o), .strobe_oe_o(strobe_oe_o), .mask_invert_n_i(mk_i),
        .mask_invert_n_o(mask_invert_n_o), .mask_invert_n_oe_o(mask_invert_n_oe_o),
        .ck_t_i(ck_t_i), .cs_n_i(cs_n_i), .parity_i(parity_i), .cmd_i(cmd_i),
        .alert_n_i(al_i), .alert_n_o(alert_n_o), .alert_oe_o(alert_oe_o),
        .vref_monitor_o(vref_monitor_o), .irq_o(irq_o));
    ddr4_ctrl_model ddr4_ctrl_model_inst (
        .clock_i(clock_i), .dq_o(m_dq), .strobe_t_o(m_st), .strobe_c_o(m_sc), .mask_n_o(m_mask));
    // ==========================================
    // Tasks
    task automatic print_verdict;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic give_up;
        num_errors++;
        print_verdict();
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        slv = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
        if (n >= 20) give_up();
    endtask
    task automatic burst(input logic [7:0] base, input logic [7:0] low);
        ddr4_ctrl_model_inst.frame(base, ~low, 1'b0, 1'b0);
        repeat (8) @(posedge clock_i);
    endtask
    task automatic chk_mem(input logic [7:0] base, input logic [7:0] prev,
                           input logic [7:0] low, input int mode);
        logic [7:0] e;
        for (int k = 0; k < BURST; k++) begin
            e = base + 8'(k);
            if (low[k] && mode == 1) e = prev + 8'(k);
            if (low[k] && mode == 2) e = ~e;
            apb(1'b0, MEM_OFF + 8'(4 * k), 32'h0000_0000);
            chk("mem_word", rd, {24'h00_0000, e});
        end
    endtask
    task automatic alert_len(input logic [31:0] exp);
        int n;
        n = 0;
        while (alert_n_o !== 1'b0 && n < 60) begin
            @(posedge clock_i);
            n++;
        end
        n = 0;
        while (alert_n_o === 1'b0 && n < 60) begin
            @(posedge clock_i);
            n++;
        end
        chk("alert_low_cycles", 32'(n), exp);
    endtask
    // ==========================================
    // Sequence
    initial begin
        int n;
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        apb(1'b0, MODE1_OFF, 32'h0000_0000);
        chk("mode_reset", rd, {16'h0000, MR_RST});
        chk("idle_pins", {28'h000_0000, alert_n_o, alert_oe_o, irq_o, dq_oe_o}, 32'h0000_000C);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped_err", {31'h0, slv}, 32'h0000_0001);
        chk("unmapped_data", rd, 32'h0000_0000);
        apb(1'b1, MASK_OFF, 32'h0000_0004);
        burst(8'h10, 8'h00);
        apb(1'b0, STAT_OFF, 32'h0000_0000);
        chk("write_done", rd, 32'h0000_0004);
        chk("irq_set", {31'h0, irq_o}, 32'h0000_0001);
        apb(1'b1, STAT_OFF, 32'h0000_000F);
        apb(1'b1, CTRL_OFF, 32'h0000_0001);
        n = 0;
        while (dq_oe_o !== 1'b1 && n < 10) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 10) give_up();
        for (int k = 0; k < BURST; k++) begin
            chk("read_beat", {24'h00_0000, dq_o}, 32'(16 + k));
            chk("read_strobe", {29'h0, strobe_oe_o, strobe_t_o, strobe_c_o},
                k[0] ? 32'h5 : 32'h6);
            repeat (4) @(posedge clock_i);
        end
        repeat (2) @(posedge clock_i);
        apb(1'b0, STAT_OFF, 32'h0000_0000);
        chk("read_done", rd, 32'h0000_0008);
        chk("irq_masked", {30'h0, irq_o, dq_oe_o}, 32'h0000_0000);
        apb(1'b1, MODE5_OFF, 32'(1 << DM_BIT));
        burst(8'h80, 8'h08);
        chk_mem(8'h80, 8'h10, 8'h08, 1);
        apb(1'b1, MODE5_OFF, 32'(1 << WDBI_BIT));
        burst(8'hC0, 8'h05);
        chk_mem(8'hC0, 8'h80, 8'h05, 2);
        apb(1'b1, MODE1_OFF, 32'(1 << TDQS_BIT));
        apb(1'b1, MODE5_OFF, 32'(1 << DM_BIT));
        burst(8'hA0, 8'h01);
        chk_mem(8'hA0, 8'hC0, 8'h01, 0);
        apb(1'b1, MODE5_OFF, 32'h0000_0000);
        apb(1'b1, CTRL_OFF, 32'h0000_0002);
        for (int b = 0; b < 2; b++) begin
            ddr4_ctrl_model_inst.frame(8'h30, 8'hFF, 1'b1, b[0]);
            alert_len(b[0] ? 32'(PULSE_CYC) : 32'h0);
        end
        apb(1'b0, STAT_OFF, 32'h0000_0000);
        chk("crc_flag", {31'h0, rd[ST_CRC]}, 32'h0000_0001);
        apb(1'b1, CTRL_OFF, 32'h0000_0000);
        apb(1'b1, MODE5_OFF, 32'h0000_0001);
        for (int p = 0; p < 2; p++) begin
            cs_n_i   <= 1'b0;
            cmd_i    <= 22'h00_0001;
            parity_i <= ~p[0];
            repeat (4) @(posedge clock_i);
            ck_t_i <= 1'b1;
            alert_len(p[0] ? 32'(RECOV_CYC) : 32'h0);
            ck_t_i <= 1'b0;
            cs_n_i <= 1'b1;
            repeat (4) @(posedge clock_i);
        end
        apb(1'b0, STAT_OFF, 32'h0000_0000);
        chk("parity_flag", {31'h0, rd[ST_PAR]}, 32'h0000_0001);
        apb(1'b1, MODE4_OFF, 32'(1 << VREF_BIT));
        alert_drv <= 1'b0;
        apb(1'b1, CTRL_OFF, 32'h0000_0054);
        repeat (4) @(posedge clock_i);
        chk("vref_lanes", {28'h000_0000, vref_monitor_o}, 32'h0000_0005);
        chk("alert_dir", {31'h0, alert_oe_o}, 32'h0000_0000);
        apb(1'b0, CTRL_OFF, 32'h0000_0000);
        chk("alert_in", {31'h0, rd[ALIN_BIT]}, 32'h0000_0000);
        print_verdict();
    end
endmodule
